/* File: lem_device.sv */
// Receive-side link error monitor with lock tracking and sequence test.
//
// Behaviour
// - Count decoding errors in readable 8-bit counter.
// - Error rate quarter or more drops lock, relocks.
// - Counter clears on lock, read, auto clear.
// - Sequence test tallies separately, decode count zero.
// - Error line low when count exceeds threshold.
// - In test, error low after one mismatch.
// - Error line released whenever decode counter clears.
// - Reading either error register clears it.
// - Auto clear fires one microsecond after error.
// - Auto clear off at reset, bit 5.
// - No auto clear during sequence test.
// - Controller disables encryption, glitch filters before test.
// - Test enabled on serializer, then device.
// - Test disabled on device, then serializer.
// - Lock output shows video link only.
//
// Design decision made here: the APB register port.
`timescale 1ns/100ps
module lem_device
  import lem_pkg::*;
#(
  parameter int WIN_SYMS = 8,
  parameter int RELOCK_SYMS = 16
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  lem_link_if.dev link,
  input wire logic sym_valid,
  input wire logic sym_err,
  input wire logic seq_err,
  output logic video_lock,
  output logic seq_test_enable,
  output logic hsync_glitch_filter_off,
  output logic vsync_glitch_filter_off,
  output logic de_glitch_filter_off,
  output logic encrypt_enable
);
  // Window and relock sizes must fit the 8-bit counters.
  if (WIN_SYMS < 4 || WIN_SYMS > 255 || RELOCK_SYMS < 1 || RELOCK_SYMS > 255) begin : g_chk
    $error("lem_device: WIN_SYMS or RELOCK_SYMS out of range");
  end

  lem_lock_st_t lock_q;
  logic ack_q;
  logic [7:0] rdata_q;
  logic [7:0] test_q;
  logic [7:0] filt_q;
  logic [7:0] auto_q;
  logic [7:0] thr_q;
  logic [7:0] dec_q;
  logic [7:0] dec_d;
  logic [7:0] seq_q;
  logic [7:0] seq_d;
  logic [7:0] win_cnt_q;
  logic [7:0] win_err_q;
  logic [7:0] clean_q;
  logic [7:0] aq_q;
  logic err_q;
  logic take;
  logic wr;
  logic rd_dec;
  logic rd_seq;
  logic test_on;
  logic auto_on;
  logic win_last;
  logic [9:0] win_tot;
  logic lose;
  logic gain;
  logic dec_inc;
  logic dec_clr;
  logic seq_inc;
  logic auto_fire;
  logic err_cond;

  // Register port decode; one request taken per ack.
  assign take = link.req && !ack_q;
  assign wr = take && link.we;
  assign rd_dec = take && !link.we && (link.addr == OFS_DEC);
  assign rd_seq = take && !link.we && (link.addr == OFS_SEQ);
  assign test_on = test_q[BIT_TEST_EN];
  assign auto_on = auto_q[BIT_AUTO_CLR];

  // Error rate check over a window of symbols while locked.
  assign win_last = (win_cnt_q == 8'(WIN_SYMS - 1));
  assign win_tot = {2'b00, win_err_q} + {9'h000, sym_err};
  assign lose = (lock_q == LEM_LOCKED) && sym_valid && win_last &&
                ({win_tot, 2'b00} >= 12'(WIN_SYMS));
  assign gain = (lock_q == LEM_SEARCH) && sym_valid && !sym_err &&
                (clean_q == 8'(RELOCK_SYMS - 1));

  // Counter update terms.
  assign dec_inc = (lock_q == LEM_LOCKED) && sym_valid && sym_err && !test_on;
  assign auto_fire = auto_on && !test_on && err_q &&
                     (aq_q == 8'(AUTO_CLR_CYC - 1));
  assign dec_clr = gain || rd_dec || auto_fire;
  assign seq_inc = test_on && seq_err;

  // Next decode count: a new error in a clearing cycle survives.
  always_comb begin
    if (test_on) begin
      dec_d = 8'h00;
    end else if (dec_clr) begin
      dec_d = dec_inc ? 8'h01 : 8'h00;
    end else if (dec_inc) begin
      dec_d = lem_sat_inc(dec_q);
    end else begin
      dec_d = dec_q;
    end
  end

  // Next test mismatch count, cleared by its read.
  always_comb begin
    if (rd_seq) begin
      seq_d = seq_inc ? 8'h01 : 8'h00;
    end else if (seq_inc) begin
      seq_d = lem_sat_inc(seq_q);
    end else begin
      seq_d = seq_q;
    end
  end

  // Error line condition from the current counts.
  assign err_cond = test_on ? (seq_q != 8'h00) : (dec_q > thr_q);

  // Lock state machine: hunt for clean symbols, drop on bad rate.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_q <= LEM_SEARCH;
    end else begin
      case (lock_q)
        LEM_SEARCH: begin
          if (gain) begin
            lock_q <= LEM_LOCKED;
          end
        end
        LEM_LOCKED: begin
          if (lose) begin
            lock_q <= LEM_SEARCH;
          end
        end
        default: lock_q <= LEM_SEARCH;
      endcase
    end
  end

  // Clean symbol run length while hunting for lock.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      clean_q <= 8'h00;
    end else if (lock_q == LEM_LOCKED || (sym_valid && sym_err) || gain) begin
      clean_q <= 8'h00;
    end else if (sym_valid) begin
      clean_q <= clean_q + 8'h01;
    end
  end

  // Symbol window position and errors within it.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      win_cnt_q <= 8'h00;
      win_err_q <= 8'h00;
    end else if (lock_q != LEM_LOCKED || (sym_valid && win_last)) begin
      win_cnt_q <= 8'h00;
      win_err_q <= 8'h00;
    end else if (sym_valid) begin
      win_cnt_q <= win_cnt_q + 8'h01;
      win_err_q <= win_tot[7:0];
    end
  end

  // Error counters.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dec_q <= 8'h00;
      seq_q <= 8'h00;
    end else begin
      dec_q <= dec_d;
      seq_q <= seq_d;
    end
  end

  // Auto clear timer, running while the error line is low.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      aq_q <= 8'h00;
    end else if (!auto_on || test_on || !err_q || auto_fire) begin
      aq_q <= 8'h00;
    end else begin
      aq_q <= aq_q + 8'h01;
    end
  end

  // Registered error line drive.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      err_q <= 1'b0;
    end else begin
      err_q <= err_cond && !dec_clr;
    end
  end

  // Writable registers.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      test_q <= 8'h00;
      filt_q <= FILT_RST;
      auto_q <= 8'h00;
      thr_q <= THR_RST;
    end else if (wr) begin
      case (link.addr)
        OFS_TEST: test_q <= link.wdata & TEST_ON_VAL;
        OFS_FILT: filt_q <= link.wdata & 8'h0f;
        OFS_AUTO: auto_q <= link.wdata & (8'h01 << BIT_AUTO_CLR);
        OFS_THR: thr_q <= link.wdata;
        default: thr_q <= thr_q;
      endcase
    end
  end

  // Read data and acknowledge, one cycle after the request is taken.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      ack_q <= take;
      if (take && !link.we) begin
        case (link.addr)
          OFS_TEST: rdata_q <= test_q;
          OFS_FILT: rdata_q <= filt_q;
          OFS_AUTO: rdata_q <= auto_q;
          OFS_DEC: rdata_q <= dec_q;
          OFS_SEQ: rdata_q <= seq_q;
          OFS_THR: rdata_q <= thr_q;
          default: rdata_q <= 8'h00;
        endcase
      end
    end
  end

  // Interface and user side outputs.
  assign link.ack = ack_q;
  assign link.rdata = rdata_q;
  assign link.err_o = 1'b0;
  assign link.err_oe = err_q;
  assign link.lock = (lock_q == LEM_LOCKED);
  assign video_lock = (lock_q == LEM_LOCKED);
  assign seq_test_enable = test_on;
  assign hsync_glitch_filter_off = filt_q[BIT_HS_OFF];
  assign vsync_glitch_filter_off = filt_q[BIT_VS_OFF];
  assign de_glitch_filter_off = filt_q[BIT_DE_OFF];
  assign encrypt_enable = filt_q[BIT_ENC_EN];
endmodule

/* File: lem_pkg.sv */
// Shared constants, register map and types of the link error monitor.
package lem_pkg;
  // Timing of the automatic error clear.
  localparam int REF_MHZ = 40;
  localparam int AUTO_CLR_NS = 1000;
  localparam int AUTO_CLR_CYC = (AUTO_CLR_NS * REF_MHZ) / 1000;
  // Device register offsets.
  localparam logic [4:0] OFS_TEST = 5'h04;
  localparam logic [4:0] OFS_FILT = 5'h05;
  localparam logic [4:0] OFS_AUTO = 5'h06;
  localparam logic [4:0] OFS_DEC = 5'h0d;
  localparam logic [4:0] OFS_SEQ = 5'h0e;
  localparam logic [4:0] OFS_THR = 5'h0f;
  // Device field positions.
  localparam int BIT_TEST_EN = 5;
  localparam int BIT_AUTO_CLR = 5;
  localparam int BIT_HS_OFF = 0;
  localparam int BIT_VS_OFF = 1;
  localparam int BIT_DE_OFF = 2;
  localparam int BIT_ENC_EN = 3;
  // Device reset values and fixed write values.
  localparam logic [7:0] THR_RST = 8'h00;
  localparam logic [7:0] FILT_RST = 8'h00;
  localparam logic [7:0] FILT_TEST_VAL = 8'h07;
  localparam logic [7:0] TEST_ON_VAL = 8'h20;
  localparam logic [7:0] TEST_OFF_VAL = 8'h00;
  // Controller register offsets on the bus.
  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_TEST = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [7:0] A_ISTAT = 8'h0c;
  localparam logic [7:0] A_IMASK = 8'h10;
  // Controller field positions.
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_WE_BIT = 16;
  localparam int EV_DONE = 0;
  localparam int EV_LOCK_LOST = 1;
  localparam int EV_ERR = 2;
  typedef enum logic {
    LEM_SEARCH = 1'b0,
    LEM_LOCKED = 1'b1
  } lem_lock_st_t;
  typedef enum logic [2:0] {
    LEM_C_IDLE = 3'b000,
    LEM_C_CMD = 3'b001,
    LEM_C_PRE = 3'b010,
    LEM_C_DON = 3'b011,
    LEM_C_DOFF = 3'b100
  } lem_ctl_st_t;
  // Saturating increment of an 8-bit count.
  function automatic logic [7:0] lem_sat_inc(input logic [7:0] v);
    lem_sat_inc = (v == 8'hff) ? v : v + 8'h01;
  endfunction
endpackage

/* File: lem_link_if.sv */
// Interface joining the monitoring device and its controller.
`timescale 1ns/100ps
interface lem_link_if;
  logic req;
  logic we;
  logic [4:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;
  logic err_o;
  logic err_oe;
  logic lock;
  logic err_n;
  // Open-drain error line with its pull-up.
  assign err_n = (err_oe && !err_o) ? 1'b0 : 1'b1;
  modport dev(input req, we, addr, wdata, output rdata, ack, err_o, err_oe, lock);
  modport ctrl(output req, we, addr, wdata, input rdata, ack, err_n, lock);
endinterface

/* File: lem_ctrl.sv */
// Controller end: APB registers, device access engine and test sequencing.
`timescale 1ns/100ps
module lem_ctrl
  import lem_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  lem_link_if.ctrl link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic ser_seq_test_enable
);
  lem_ctl_st_t st_q;
  logic [16:0] cmd_q;
  logic [7:0] rd_q;
  logic in_test_q;
  logic ser_q;
  logic [2:0] ist_q;
  logic [2:0] imask_q;
  logic [31:0] prdata_q;
  logic lock_prev_q;
  logic err_prev_q;
  logic apb_wr;
  logic mapped;
  logic idle;
  logic [2:0] ev;
  logic [2:0] w1c;

  // Bus write strobe, address map and sequencer idle flag.
  assign apb_wr = psel && penable && pwrite;
  assign mapped = (paddr == A_CMD) || (paddr == A_TEST) || (paddr == A_STAT) ||
                  (paddr == A_ISTAT) || (paddr == A_IMASK);
  assign idle = (st_q == LEM_C_IDLE);

  // Device access request steered by the sequencer state.
  always_comb begin
    link.req = !idle;
    link.we = 1'b1;
    link.addr = OFS_TEST;
    link.wdata = TEST_OFF_VAL;
    case (st_q)
      LEM_C_CMD: begin
        link.we = cmd_q[CMD_WE_BIT];
        link.addr = cmd_q[CMD_ADDR_LSB +: 5];
        link.wdata = cmd_q[7:0];
      end
      LEM_C_PRE: begin
        link.addr = OFS_FILT;
        link.wdata = FILT_TEST_VAL;
      end
      LEM_C_DON: link.wdata = TEST_ON_VAL;
      default: link.wdata = TEST_OFF_VAL;
    endcase
  end

  // Sequencer: serializer on before device, device off before serializer.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= LEM_C_IDLE;
      ser_q <= 1'b0;
      in_test_q <= 1'b0;
    end else begin
      case (st_q)
        LEM_C_IDLE: begin
          if (apb_wr && paddr == A_CMD) begin
            st_q <= LEM_C_CMD;
          end else if (apb_wr && paddr == A_TEST && pwdata[0] && !in_test_q) begin
            st_q <= LEM_C_PRE;
          end else if (apb_wr && paddr == A_TEST && pwdata[1] && in_test_q) begin
            st_q <= LEM_C_DOFF;
          end
        end
        LEM_C_CMD: begin
          if (link.ack) begin
            st_q <= LEM_C_IDLE;
          end
        end
        LEM_C_PRE: begin
          if (link.ack) begin
            ser_q <= 1'b1;
            st_q <= LEM_C_DON;
          end
        end
        LEM_C_DON: begin
          if (link.ack) begin
            in_test_q <= 1'b1;
            st_q <= LEM_C_IDLE;
          end
        end
        LEM_C_DOFF: begin
          if (link.ack) begin
            ser_q <= 1'b0;
            in_test_q <= 1'b0;
            st_q <= LEM_C_IDLE;
          end
        end
        default: st_q <= LEM_C_IDLE;
      endcase
    end
  end

  // Command word and read result.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_q <= 17'h00000;
      rd_q <= 8'h00;
    end else begin
      if (idle && apb_wr && paddr == A_CMD) begin
        cmd_q <= pwdata[16:0];
      end
      if (st_q == LEM_C_CMD && link.ack && !cmd_q[CMD_WE_BIT]) begin
        rd_q <= link.rdata;
      end
    end
  end

  // Previous levels of the lock and error lines; both ends share ref_clk, so no synchroniser.
  // Reset values match the idle levels, so no false edge follows reset.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_prev_q <= 1'b0;
      err_prev_q <= 1'b1;
    end else begin
      lock_prev_q <= link.lock;
      err_prev_q <= link.err_n;
    end
  end

  // Sticky events; a new event wins over its clear.
  assign ev[EV_DONE] = (st_q == LEM_C_CMD) && link.ack;
  assign ev[EV_LOCK_LOST] = lock_prev_q && !link.lock;
  assign ev[EV_ERR] = err_prev_q && !link.err_n;
  assign w1c = (apb_wr && paddr == A_ISTAT) ? pwdata[2:0] : 3'b000;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ist_q <= 3'b000;
      imask_q <= 3'b000;
    end else begin
      ist_q <= (ist_q & ~w1c) | ev;
      if (apb_wr && paddr == A_IMASK) begin
        imask_q <= pwdata[2:0];
      end
    end
  end

  // Read data captured in the setup cycle.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_q <= 32'h00000000;
    end else if (psel && !penable) begin
      case (paddr)
        A_CMD: prdata_q <= {15'h0000, cmd_q};
        A_STAT: prdata_q <= {16'h0000, rd_q, 4'h0, !link.err_n, link.lock, in_test_q, !idle};
        A_ISTAT: prdata_q <= {29'h00000000, ist_q};
        A_IMASK: prdata_q <= {29'h00000000, imask_q};
        default: prdata_q <= 32'h00000000;
      endcase
    end
  end

  // Bus answer, interrupt and serializer test drive.
  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign irq = |(ist_q & imask_q);
  assign ser_seq_test_enable = ser_q;
endmodule

/* File: lem_link_assertions.sv */
// Concurrent checks on the link between the monitoring device and its controller.
`timescale 1ns/100ps
module lem_link_assertions
  import lem_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic req,
  input wire logic we,
  input wire logic [4:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic ack,
  input wire logic err_o,
  input wire logic err_oe,
  input wire logic lock,
  input wire logic err_n
);
  logic test_q;
  logic auto_q;
  logic [7:0] hi_q;
  wire take = req && !ack;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Mirror the mode bits from the writes that the device takes.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      test_q <= 1'b0;
      auto_q <= 1'b0;
    end else if (take && we) begin
      if (addr == OFS_TEST) test_q <= wdata[BIT_TEST_EN];
      if (addr == OFS_AUTO) auto_q <= wdata[BIT_AUTO_CLR];
    end
  end
  // Count how long the error line has been pulled low, saturating.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hi_q <= 8'h00;
    end else if (!err_oe) begin
      hi_q <= 8'h00;
    end else if (hi_q != 8'hff) begin
      hi_q <= hi_q + 8'h01;
    end
  end
  sequence s_take;
    req && !ack;
  endsequence
  sequence s_ack_once;
    ack ##1 !ack;
  endsequence
  chk_ack_pulse: assert property (s_take |=> s_ack_once)
    else $error("device access not answered by one ack pulse");
  chk_ack_cause: assert property (ack |-> $past(req) && !$past(ack))
    else $error("ack without a taken request");
  chk_err_line: assert property (err_n == !err_oe && err_o == 1'b0)
    else $error("error line is not open drain low");
  chk_dec_clear: assert property (s_take and (!we && addr == OFS_DEC && !test_q)
    |=> !err_oe)
    else $error("error line held after decode count read");
  chk_seq_clear: assert property (s_take and (!we && addr == OFS_SEQ && test_q)
    |-> ##[1:2] !err_oe)
    else $error("error line held after mismatch count read");
  chk_lock_clear: assert property ($rose(lock) && !test_q |-> ##[0:1] !err_oe)
    else $error("error line held after lock gain");
  chk_err_hold: assert property ((!auto_q || test_q) && err_oe && !req && lock
    |=> err_oe)
    else $error("error line released without a clearing cause");
  chk_auto_bound: assert property (auto_q && !test_q |-> hi_q <= AUTO_CLR_CYC + 2)
    else $error("automatic clear did not fire in time");
endmodule

/* File: test_link_error_monitor.sv */
// Self-checking testbench of the link error monitor with both ends joined.
`timescale 1ns/100ps
module test_link_error_monitor;
  import lem_pkg::*;
  logic ref_clk, rst_b, sym_valid, sym_err, seq_err, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, irq, ser, slv, video_lock, dev_test, hs_off, vs_off, de_off, enc;
  logic order_bad = 1'b0;
  int low_run = 0;
  int low_len = 0;
  int miscompares = 0;
  int checks = 0;
  lem_link_if lnk();
  lem_device #(.WIN_SYMS(8), .RELOCK_SYMS(4)) i_lem_device (.ref_clk(ref_clk),
    .rst_b(rst_b), .link(lnk.dev), .sym_valid(sym_valid), .sym_err(sym_err),
    .seq_err(seq_err), .video_lock(video_lock), .seq_test_enable(dev_test),
    .hsync_glitch_filter_off(hs_off), .vsync_glitch_filter_off(vs_off),
    .de_glitch_filter_off(de_off), .encrypt_enable(enc));
  lem_ctrl i_lem_ctrl (.ref_clk(ref_clk), .rst_b(rst_b), .link(lnk.ctrl), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .ser_seq_test_enable(ser));
  lem_link_assertions i_lem_link_assertions (.ref_clk(ref_clk), .rst_b(rst_b),
    .req(lnk.req), .we(lnk.we), .addr(lnk.addr), .wdata(lnk.wdata), .rdata(lnk.rdata),
    .ack(lnk.ack), .err_o(lnk.err_o), .err_oe(lnk.err_oe), .lock(lnk.lock),
    .err_n(lnk.err_n));
  // Clock at 40 MHz.
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Device test mode must never be on while the serializer's is off.
  always @(posedge ref_clk) if (dev_test === 1'b1 && ser !== 1'b1) order_bad <= 1'b1;
  // Length of the last low run of the error line.
  always @(posedge ref_clk) begin
    if (lnk.err_n === 1'b0) begin
      low_run <= low_run + 1;
    end else if (low_run != 0) begin
      low_len <= low_run;
      low_run <= 0;
    end
  end
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic give_up();
    miscompares++;
    $display("[FAIL] wait expected done seen timeout");
    end_of_test();
  endtask
  // One APB transfer; read data and slave error land in q and slv.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) give_up();
    q = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, A_STAT, 32'h0);
      n++;
    end while (q[b] !== v && n < 20);
    if (n >= 20) give_up();
  endtask
  // Device register access through the controller's command register.
  task automatic dev(input logic w, input logic [4:0] a, input logic [7:0] d);
    apb(1'b1, A_CMD, {15'h0000, w, 3'h0, a, d});
    poll(0, 1'b0);
  endtask
  // Symbols with an error on every per-th one; per 0 means clean.
  task automatic syms(input int n, input int per);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      sym_valid <= 1'b1;
      sym_err <= (per != 0 && i % per == 0);
    end
    @(posedge ref_clk);
    sym_valid <= 1'b0;
    sym_err <= 1'b0;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic t_reset();
    chk("err_n", lnk.err_n, 1'b1);
    chk("lock", lnk.lock, 1'b0);
    chk("irq", irq, 1'b0);
    apb(1'b0, 8'h14, 32'h0);
    chk("pslverr", slv, 1'b1);
    dev(1'b0, OFS_AUTO, 8'h00);
    chk("auto_rst", q[15:8], 8'h00);
    syms(8, 0);
    chk("lock_on", lnk.lock, 1'b1);
    chk("video_lock", video_lock, 1'b1);
  endtask
  task automatic t_count();
    apb(1'b1, A_IMASK, 32'h4);
    syms(24, 8);
    chk("err_low", lnk.err_n, 1'b0);
    chk("irq_on", irq, 1'b1);
    apb(1'b1, A_ISTAT, 32'h4);
    chk("irq_off", irq, 1'b0);
    dev(1'b0, OFS_DEC, 8'h00);
    chk("dec3", q[15:8], 8'h03);
    chk("err_rel", lnk.err_n, 1'b1);
    dev(1'b0, OFS_DEC, 8'h00);
    chk("dec0", q[15:8], 8'h00);
    syms(2080, 8);
    dev(1'b0, OFS_DEC, 8'h00);
    chk("dec_sat", q[15:8], 8'hff);
    dev(1'b1, OFS_THR, 8'h02);
    syms(16, 8);
    chk("thr_eq", lnk.err_n, 1'b1);
    syms(8, 8);
    chk("thr_over", lnk.err_n, 1'b0);
    dev(1'b0, OFS_DEC, 8'h00);
    dev(1'b1, OFS_THR, 8'h00);
  endtask
  task automatic t_loss();
    syms(16, 1);
    chk("lost", lnk.lock, 1'b0);
    apb(1'b0, A_ISTAT, 32'h0);
    chk("ev_lost", q[1], 1'b1);
    syms(8, 0);
    chk("relock", lnk.lock, 1'b1);
    chk("relock_err", lnk.err_n, 1'b1);
    dev(1'b0, OFS_DEC, 8'h00);
    chk("dec_relock", q[15:8], 8'h00);
  endtask
  task automatic t_auto();
    dev(1'b1, OFS_AUTO, 8'h20);
    dev(1'b0, OFS_AUTO, 8'h00);
    chk("auto_rd", q[15:8], 8'h20);
    syms(8, 8);
    repeat (60) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("auto_len", low_len >= 39 && low_len <= 42, 1'b1);
    dev(1'b0, OFS_DEC, 8'h00);
    chk("auto_dec", q[15:8], 8'h00);
  endtask
  task automatic t_seq();
    dev(1'b1, OFS_FILT, 8'h08);
    apb(1'b1, A_TEST, 32'h1);
    poll(1, 1'b1);
    chk("ser_on", ser, 1'b1);
    chk("dev_on", dev_test, 1'b1);
    chk("filt", {enc, de_off, vs_off, hs_off}, 4'h7);
    syms(16, 1);
    dev(1'b0, OFS_DEC, 8'h00);
    chk("dec_test", q[15:8], 8'h00);
    chk("err_idle", lnk.err_n, 1'b1);
    @(posedge ref_clk);
    seq_err <= 1'b1;
    @(posedge ref_clk);
    seq_err <= 1'b0;
    repeat (60) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("seq_err", lnk.err_n, 1'b0);
    dev(1'b0, OFS_SEQ, 8'h00);
    chk("seq_cnt", q[15:8], 8'h01);
    chk("seq_rel", lnk.err_n, 1'b1);
    apb(1'b1, A_TEST, 32'h2);
    poll(1, 1'b0);
    chk("ser_off", ser, 1'b0);
    chk("dev_off", dev_test, 1'b0);
    chk("order", order_bad, 1'b0);
  endtask
  // Reset for ten cycles, then the scenarios in turn.
  initial begin
    rst_b = 1'b0;
    {sym_valid, sym_err, seq_err, psel, penable, pwrite} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(negedge ref_clk);
    t_reset();
    t_count();
    t_loss();
    t_auto();
    t_seq();
    end_of_test();
  end
endmodule
